// ===== common/uhf_pkg.sv
package uhf_pkg;
  // System clock and serial timing
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_MAX = 1000000;
  // Least divider: one bit time at the fastest rate
  localparam int DIV_MIN = CLK_HZ / BAUD_MAX;
  localparam int DIV_W = 16;
  localparam logic [15:0] DIV_RESET = 16'h01b2;
  // Character layout
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_CNT_W = 4;
  // Unused width; mid-bit sampling sits at half the divider within a bit time
  localparam int OVS_W = 16;
  // Pin levels
  localparam logic LINE_IDLE = 1'b1;
  localparam logic HS_ASSERT = 1'b0;
  localparam logic HS_DEASSERT = 1'b1;
  localparam logic START_LVL = 1'b0;
  localparam logic STOP_LVL = 1'b1;
  // Free entries left when the request line is withdrawn
  localparam int RTS_MARGIN = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } uhf_state_type;
endpackage

// ===== logic/uhf_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push;
  wire pop;

  ////////////////////////////////////////////////////////////////////
  // Honest flags; a full FIFO refuses, an empty one offers nothing
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  assign level = count;

  // Storage has no reset; only pointers matter
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== logic/uhf_uart.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Full duplex port, up to one megabit
// - Optional ninth parity bit, generated and checked
// - Hardware flow control: request out, clear in
// - Handshake lines are active low
// - Transmit line rests high when idle
// - Serial output driven high after reset
// - Request output driven low after reset
// - Receive input pulled up, idle high
// - Clear input pulled down, reads asserted
// - Host transmit feeds receive, host receive takes transmit
// - Device holds two independent instances of port; the code has one uhf_uart, instantiated once by the test
module uhf_uart (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [uhf_pkg::DIV_W-1:0] baud_div,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [uhf_pkg::DATA_W-1:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [uhf_pkg::DATA_W-1:0] rx_data,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic rx_overrun,
  output logic pin_serial_out,
  input wire logic pin_serial_in,
  output logic pin_request_out,
  input wire logic pin_clear_in
);
  import uhf_pkg::*;

  // Parity over the data byte, even or odd
  function automatic logic par_of(input logic [DATA_W-1:0] d,
                                  input logic odd);
    par_of = (^d) ^ odd;
  endfunction

  // Divider clamp: never faster than the top rate
  function automatic logic [DIV_W-1:0] eff_div(input logic [DIV_W-1:0] d);
    eff_div = (d < DIV_W'(DIV_MIN)) ? DIV_W'(DIV_MIN) : d;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Transmitter: runs alongside the receiver
  uhf_state_type tx_state;
  logic [DIV_W-1:0] tx_cnt;
  logic [BIT_CNT_W-1:0] tx_bit;
  logic [DATA_W:0] tx_shift;
  logic tx_line;
  wire [DIV_W-1:0] div_now;
  wire tx_tick;
  wire tx_last_bit;
  wire tx_go;

  assign div_now = eff_div(baud_div);
  assign tx_tick = (tx_cnt == div_now - 1'b1);
  assign tx_last_bit = (tx_bit == (parity_en ? BIT_CNT_W'(DATA_W)
                                             : BIT_CNT_W'(DATA_W - 1)));
  // Start only while clear is low; a frame in flight finishes
  // An open clear pin reads low through the pad pull-down, so sends go
  assign tx_go = tx_valid && (pin_clear_in == HS_ASSERT);
  assign tx_ready = (tx_state == ST_IDLE) && (pin_clear_in == HS_ASSERT);
  assign pin_serial_out = tx_line;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_state <= ST_IDLE;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_shift <= '0;
      tx_line <= LINE_IDLE;
    end else begin
      tx_cnt <= (tx_state == ST_IDLE || tx_tick) ? '0 : tx_cnt + 1'b1;
      case (tx_state)
        ST_IDLE: begin
          tx_line <= LINE_IDLE;
          if (tx_go) begin
            tx_shift <= {par_of(tx_data, parity_odd), tx_data};
            tx_line <= START_LVL;
            tx_state <= ST_START;
          end
        end
        ST_START: begin
          if (tx_tick) begin
            tx_line <= tx_shift[0];
            tx_bit <= '0;
            tx_state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_tick) begin
            if (tx_last_bit) begin
              tx_line <= STOP_LVL;
              tx_state <= ST_STOP;
            end else begin
              tx_line <= tx_shift[tx_bit + 1'b1];
              tx_bit <= tx_bit + 1'b1;
            end
          end
        end
        ST_STOP: begin
          if (tx_tick) begin
            tx_state <= ST_IDLE;
          end
        end
        default: begin
          tx_state <= ST_IDLE;
          tx_line <= LINE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver; line is taken as synchronous, a glitch start is dropped
  uhf_state_type rx_state;
  logic [DIV_W-1:0] rx_cnt;
  logic [BIT_CNT_W-1:0] rx_bit;
  logic [DATA_W:0] rx_shift;
  logic [DATA_W-1:0] fifo_word;
  logic fifo_push;
  logic frame_err;
  logic parity_err;
  logic overrun;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic fifo_in_ready;
  wire rx_mid;
  wire rx_end;
  wire rx_last_bit;

  assign rx_mid = (rx_cnt == {1'b0, div_now[DIV_W-1:1]});
  assign rx_end = (rx_cnt == div_now - 1'b1);
  assign rx_last_bit = (rx_bit == (parity_en ? BIT_CNT_W'(DATA_W)
                                             : BIT_CNT_W'(DATA_W - 1)));

  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_state <= ST_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_shift <= '0;
      fifo_push <= 1'b0;
      fifo_word <= '0;
      frame_err <= 1'b0;
      parity_err <= 1'b0;
    end else begin
      fifo_push <= 1'b0;
      rx_cnt <= (rx_state == ST_IDLE || rx_end) ? '0 : rx_cnt + 1'b1;
      case (rx_state)
        ST_IDLE: begin
          // Pad pull-up makes an open line read idle high; host drives it
          if (pin_serial_in == START_LVL) rx_state <= ST_START;
        end
        ST_START: begin
          // Start bit rechecked at its middle
          if (rx_mid && pin_serial_in != START_LVL) rx_state <= ST_IDLE;
          else if (rx_end) begin
            rx_bit <= '0;
            rx_state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_mid) rx_shift[rx_bit] <= pin_serial_in;
          if (rx_end) begin
            if (rx_last_bit) rx_state <= ST_STOP;
            else rx_bit <= rx_bit + 1'b1;
          end
        end
        ST_STOP: begin
          // Finish at mid stop so the next start is not missed
          if (rx_mid) begin
            fifo_word <= rx_shift[DATA_W-1:0];
            fifo_push <= 1'b1;
            frame_err <= (pin_serial_in != STOP_LVL);
            parity_err <= parity_en &&
              (rx_shift[DATA_W] != par_of(rx_shift[DATA_W-1:0],
                                          parity_odd));
            rx_state <= ST_IDLE;
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // Sticky overrun: a push into a full FIFO loses the char; set beats clear
  always_ff @(posedge mclk) begin
    if (reset) overrun <= 1'b0;
    else if (fifo_push && !fifo_in_ready) overrun <= 1'b1;
    else if (rx_valid && rx_ready) overrun <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Receive buffer; its fill level drives the request line
  // Each copy owns its buffer, so two ports on a chip never share state
  uhf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) i_uhf_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .level(fifo_level)
  );

  // Withdraw request with margin, host may be mid character
  always_ff @(posedge mclk) begin
    if (reset) pin_request_out <= HS_ASSERT;
    else pin_request_out <= (fifo_level >= (FIFO_DEPTH - RTS_MARGIN))
      ? HS_DEASSERT : HS_ASSERT;
  end

  // Parity and frame flags travel with the last character pushed; overrun is sticky
  assign rx_parity_err = parity_err;
  assign rx_frame_err = frame_err;
  assign rx_overrun = overrun;
endmodule
`default_nettype wire

// ===== testbench/uhf_host.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_host #(
  parameter int DIV = 50
) (
  input wire logic mclk,
  input wire logic line_in,
  input wire logic rts_n,
  input wire logic par_en,
  input wire logic par_odd,
  output logic line_out,
  output logic [7:0] got_byte,
  output logic got_par,
  output int got_cnt
);
  logic [10:0] frame;
  initial begin
    line_out = 1'b1;
    got_cnt = 0;
  end
  // Waits for request unless told to overrun; bad spoils parity or stop
  task send_byte(input logic [7:0] b, input logic bad, input logic ign);
    if (!ign) wait (rts_n == 1'b0);
    @(posedge mclk);
    frame = {1'b1, par_en ? (par_odd ^ (^b) ^ bad) : !bad, b, 1'b0};
    for (int i = 0; i < (par_en ? 11 : 10); i++) begin
      #1 line_out = frame[i];
      repeat (DIV) @(posedge mclk);
    end
    // A low stop bit leaves the line low; return it to idle
    if (line_out !== 1'b1) begin
      #1 line_out = 1'b1;
      repeat (DIV) @(posedge mclk);
    end
  endtask
  // Mid-bit sampling; a low stop bit spoils the count on purpose
  always begin
    @(negedge line_in);
    repeat (DIV / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge mclk);
      got_byte[i] = line_in;
    end
    got_par = 1'b0;
    if (par_en) begin
      repeat (DIV) @(posedge mclk);
      got_par = line_in;
    end
    repeat (DIV) @(posedge mclk);
    got_cnt = got_cnt + (line_in ? 1 : 100);
  end
endmodule
`default_nettype wire

// ===== testbench/uhf_uart_checker.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_uart_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_overrun,
  input wire logic pin_serial_out,
  input wire logic pin_request_out,
  input wire logic pin_clear_in
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // A take, then a start bit far longer than eight cycles
  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_start_low;
    !pin_serial_out [*8];
  endsequence
  a_reset_line_high: assert property ($fell(reset) |-> pin_serial_out)
    else $error("line low after reset");
  a_reset_req_low: assert property ($fell(reset) |-> !pin_request_out)
    else $error("request high after reset");
  a_reset_rx_empty: assert property ($fell(reset) |-> !rx_valid)
    else $error("rx valid after reset");
  a_take_start_bit: assert property (s_take |=> s_start_low)
    else $error("no start bit after take");
  a_ready_needs_clear: assert property (tx_ready |-> !pin_clear_in)
    else $error("ready while clear withdrawn");
  a_busy_refuses: assert property (s_take |=> !tx_ready [*8])
    else $error("ready while sending");
  a_idle_line_high: assert property (tx_ready |-> pin_serial_out)
    else $error("idle line low");
  a_overrun_halts: assert property (rx_overrun |-> pin_request_out)
    else $error("request low while full");
endmodule
`default_nettype wire

// ===== testbench/uhf_uart_test.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_uart_test;
  logic mclk = 1'b0, reset = 1'b1, parity_en = 1'b0, parity_odd = 1'b0;
  logic tx_valid = 1'b0, rx_ready = 1'b0, pin_clear_in = 1'b0;
  logic [15:0] baud_div = 16'h0032;
  logic [7:0] tx_data = 8'h00;
  wire logic tx_ready, rx_valid, rx_parity_err, rx_overrun, h_par;
  wire logic rx_frame_err, pin_serial_out, pin_serial_in, pin_request_out;
  wire logic [7:0] rx_data, h_byte;
  int h_cnt;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  uhf_uart i_uhf_uart (.mclk(mclk), .reset(reset), .baud_div(baud_div),
    .parity_en(parity_en), .parity_odd(parity_odd), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun),
    .pin_serial_out(pin_serial_out), .pin_serial_in(pin_serial_in),
    .pin_request_out(pin_request_out), .pin_clear_in(pin_clear_in));
  uhf_host #(.DIV(50)) i_uhf_host (.mclk(mclk), .line_in(pin_serial_out),
    .rts_n(pin_request_out), .par_en(parity_en), .par_odd(parity_odd),
    .line_out(pin_serial_in), .got_byte(h_byte), .got_par(h_par),
    .got_cnt(h_cnt));
  initial forever #10 mclk = ~mclk;
  // Cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // Inputs move 1 ns after the edge
  task ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Valid stands until the edge that sees ready high, then drops
  task tx_put(input logic [7:0] b);
    bit took;
    took = 1'b0;
    tx_data = b;
    tx_valid = 1'b1;
    for (int k = 0; k < 2000 && !took; k++) begin
      @(posedge mclk);
      took = (tx_ready === 1'b1);
    end
    #1 tx_valid = 1'b0;
    chk("tx take", 8'h01, 8'(took));
  endtask
  task wait_host(input int n);
    for (int k = 0; k < 2000 && h_cnt != n; k++) ticks(1);
  endtask
  task pop(input logic [7:0] e);
    for (int k = 0; k < 2000 && rx_valid !== 1'b1; k++) ticks(1);
    chk("rx_data", e, rx_data);
    rx_ready = 1'b1;
    ticks(1);
    rx_ready = 1'b0;
    // A free edge so a following pop never toggles ready in one step
    ticks(1);
  endtask
  task t_duplex();
    for (int m = 0; m < 3; m++) begin
      parity_en = m[0] | m[1];
      parity_odd = m[1];
      // Last pass asks for too fast a rate; the clamp keeps one megabit
      baud_div = m[1] ? 16'h0008 : 16'h0032;
      fork
        tx_put(8'h96 + m[7:0]);
        i_uhf_host.send_byte(8'h69 - m[7:0], 1'b0, 1'b0);
      join
      wait_host(m + 1);
      chk("host byte", 8'h96 + m[7:0], h_byte);
      chk("parity", 8'(parity_en & (^tx_data ^ parity_odd)), 8'(h_par));
      pop(8'h69 - m[7:0]);
      chk("parity_err", 8'h00, 8'(rx_parity_err));
    end
  endtask
  task t_bad_parity();
    i_uhf_host.send_byte(8'h3c, 1'b1, 1'b0);
    ticks(30);
    chk("parity_err", 8'h01, 8'(rx_parity_err));
    chk("frame_err", 8'h00, 8'(rx_frame_err));
    pop(8'h3c);
    parity_en = 1'b0;
    // Low stop bit without parity: flagged, data still kept
    i_uhf_host.send_byte(8'hc3, 1'b1, 1'b0);
    ticks(30);
    chk("frame_err", 8'h01, 8'(rx_frame_err));
    chk("parity_err", 8'h00, 8'(rx_parity_err));
    pop(8'hc3);
  endtask
  // A halted start, then a withdrawal in mid frame
  task t_flow();
    pin_clear_in = 1'b1;
    fork
      tx_put(8'h5a);
    join_none
    ticks(100);
    chk("halted line", 8'h01, 8'(pin_serial_out));
    chk("halted ready", 8'h00, 8'(tx_ready));
    pin_clear_in = 1'b0;
    ticks(100);
    pin_clear_in = 1'b1;
    wait_host(4);
    chk("host byte", 8'h5a, h_byte);
    pin_clear_in = 1'b0;
  endtask
  task t_fill();
    for (int i = 0; i < 17; i++) begin
      i_uhf_host.send_byte(8'h30 + i[7:0], 1'b0, i > 11);
      ticks(2);
      if (i == 11) chk("request", 8'h01, 8'(pin_request_out));
    end
    chk("overrun", 8'h01, 8'(rx_overrun));
    chk("frame_err", 8'h00, 8'(rx_frame_err));
    for (int i = 0; i < 16; i++) pop(8'h30 + i[7:0]);
    ticks(2);
    chk("request", 8'h00, 8'(pin_request_out));
    chk("overrun", 8'h00, 8'(rx_overrun));
  endtask
  initial begin
    ticks(16);
    reset = 1'b0;
    ticks(2);
    chk("serial_out", 8'h01, 8'(pin_serial_out));
    chk("request", 8'h00, 8'(pin_request_out));
    t_duplex();
    t_bad_parity();
    t_flow();
    t_fill();
    summarize();
  end
endmodule
bind uhf_uart uhf_uart_checker i_uhf_uart_checker (.mclk(mclk),
  .reset(reset), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .rx_overrun(rx_overrun),
  .pin_serial_out(pin_serial_out), .pin_request_out(pin_request_out),
  .pin_clear_in(pin_clear_in));
`default_nettype wire
